// *** src/fpl_consts.vh ***
/*
  Constants for the fixed-point sign-load and load-multiple sequencer:
  register offsets, field positions, operation codes, condition codes and
  datapath presets.
  Assumes that it is included by its bare name from each design file that uses it.
*/
`ifndef FPL_CONSTS_VH
`define FPL_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus.
// ----------------------------------------------------------------------
`define FPL_OFF_CTRL     8'h00
`define FPL_OFF_ADDR     8'h04
`define FPL_OFF_STAT     8'h08
`define FPL_GPR_SEL      2'b01

// ----------------------------------------------------------------------
// Control word fields: operation code, first field, second or third field.
// ----------------------------------------------------------------------
`define FPL_CTRL_OP_HI   15
`define FPL_CTRL_OP_LO   8
`define FPL_CTRL_F1_HI   7
`define FPL_CTRL_F1_LO   4
`define FPL_CTRL_F2_HI   3
`define FPL_CTRL_F2_LO   0

// ----------------------------------------------------------------------
// Status word bit positions.
// ----------------------------------------------------------------------
`define FPL_STAT_BUSY    0
`define FPL_STAT_CC_LO   1
`define FPL_STAT_CC_HI   2
`define FPL_STAT_ZERO    3
`define FPL_STAT_OVF     4
`define FPL_STAT_SPEC    5

// ----------------------------------------------------------------------
// Operation codes.
// ----------------------------------------------------------------------
`define FPL_OP_LOAD_COMPL  8'h13
`define FPL_OP_LOAD_ABS    8'h10
`define FPL_OP_LOAD_NEGMAG 8'h11
`define FPL_OP_LOAD_MULTI  8'h98

// ----------------------------------------------------------------------
// Condition code values.
// ----------------------------------------------------------------------
`define FPL_CC_ZERO      2'h0
`define FPL_CC_NEG       2'h1
`define FPL_CC_POS       2'h2
`define FPL_CC_OVF       2'h3

// ----------------------------------------------------------------------
// Datapath constants.
// ----------------------------------------------------------------------
`define FPL_F_PRESET     8'hc0
`define FPL_DW_STEP      24'h000008
`define FPL_WSEL_BIT     2
`define FPL_MOST_NEG     32'h80000000
`define FPL_RESP_OKAY    2'h0
`define FPL_RESP_SLVERR  2'h2

`endif

// *** src/fpl_twos_comp.v ***
/*
  Two's complement unit of the sign-load datapath.
  Assumes nothing; purely combinational.
*/
`timescale 1ns/1ps
`include "fpl_consts.vh"

module fpl_twos_comp (
  input  wire [31:0] operand,
  output wire [31:0] negated,
  output wire        negZero,
  output wire        negOverflow
);

  // --------------------------------------------------------------------
  // Negation and result tests
  // --------------------------------------------------------------------
  // Inverts and adds one; the most negative value maps onto itself.
  assign negated     = (~operand) + 32'h00000001;
  assign negZero     = (negated == 32'h00000000);
  assign negOverflow = (operand == `FPL_MOST_NEG);

endmodule // fpl_twos_comp

// *** src/fpl_word_pick.v ***
/*
  Word selector for a fetched doubleword.
  Assumes the left word sits in the upper half of the 64-bit bus.
*/
`timescale 1ns/1ps

module fpl_word_pick (
  input  wire [63:0] dword,
  input  wire        pickRight,
  output wire [31:0] word
);

  // --------------------------------------------------------------------
  // Selection
  // --------------------------------------------------------------------
  // Low select gives the left word, high select the right word.
  assign word = pickRight ? dword[31:0] : dword[63:32];

endmodule // fpl_word_pick

// *** src/fpl_exec.v ***
/*
  Sequencer for load complement, load positive, load negative and load
  multiple, with a 16-word local store and an AXI4-Lite register slave.
  Assumes the storage unit runs on sys_clk, answers each one-cycle request
  with one stDataValid pulse carrying the doubleword, in request order.
*/
// Operation
// - Complement writes negated operand to first field
// - Complement sets zero and overflow flags
// - Negating most negative value signals overflow
// - Complement code: overflow 3, zero 0, sign
// - Positive loads absolute value, tests zero, overflow
// - Positive writes operand, rewrites negated if negative
// - Positive code: overflow 3, zero 0, else 2
// - Negative loads negative magnitude, tests zero
// - Negative writes operand, rewrites negated if positive
// - Negative code: zero 0, else 1; never overflow
// - Multiple loads ascending registers, wrapping fifteen to zero
// - Alignment check first; failure suppresses whole operation
// - Equal fields: load one word chosen by address bit
// - Unequal: add eight, decrement third, compare, branch
// - Left start, match: both words, no request
// - Right start, match: request, right, then left
// - Right start, differ: right word, add four
// - Loop loads words, requests next, exits near end
// - First field increments for each further word
// - Four formed by preset, clear, nibble swap
// - End only after third-field register written
`timescale 1ns/1ps
`include "fpl_consts.vh"

module fpl_exec (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire [7:0]  s_axil_awaddr,
  input  wire        s_axil_awvalid,
  output reg         s_axil_awready,
  input  wire [31:0] s_axil_wdata,
  input  wire [3:0]  s_axil_wstrb,
  input  wire        s_axil_wvalid,
  output reg         s_axil_wready,
  output reg  [1:0]  s_axil_bresp,
  output reg         s_axil_bvalid,
  input  wire        s_axil_bready,
  input  wire [7:0]  s_axil_araddr,
  input  wire        s_axil_arvalid,
  output reg         s_axil_arready,
  output reg  [31:0] s_axil_rdata,
  output reg  [1:0]  s_axil_rresp,
  output reg         s_axil_rvalid,
  input  wire        s_axil_rready,
  output reg         stReq,
  output reg  [23:0] stAddr,
  input  wire        stDataValid,
  input  wire [63:0] storageDataOutBus
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [10:0] S_IDLE   = 11'h001;
  localparam [10:0] S_SIGN1  = 11'h002;
  localparam [10:0] S_SIGN2  = 11'h004;
  localparam [10:0] S_FETCH0 = 11'h008;
  localparam [10:0] S_CMP1   = 11'h010;
  localparam [10:0] S_BRANCH = 11'h020;
  localparam [10:0] S_ALIGN  = 11'h040;
  localparam [10:0] S_WAIT   = 11'h080;
  localparam [10:0] S_LEFT   = 11'h100;
  localparam [10:0] S_RIGHT  = 11'h200;
  localparam [10:0] S_ENDOP  = 11'h400;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg  [10:0] state;
  reg  [7:0]  opCode;
  reg  [3:0]  firstRegField;
  reg  [3:0]  thirdRegField;
  reg  [3:0]  thirdWork;
  reg  [23:0] opAddr;
  reg  [7:0]  workF;
  reg  [63:0] dwordBuf;
  reg  [31:0] tOperand;
  reg         zeroFlag;
  reg         ovfFlag;
  reg  [1:0]  condCode;
  reg         specIntr;
  reg         busy;
  reg  [31:0] localStore [0:15];
  reg         awHeld;
  reg         wHeld;
  reg  [7:0]  awAddrQ;
  reg  [31:0] wDataQ;
  reg  [3:0]  wStrbQ;
  reg         seqWe;
  reg  [3:0]  seqWa;
  reg  [31:0] seqWd;
  reg         pickRight;
  reg  [31:0] rdMux;
  reg         rdHit;
  wire [31:0] negVal;
  wire        negZero;
  wire        negOvf;
  wire [31:0] pickedWord;
  wire        doWrite;
  wire        wrHit;
  wire        wrGpr;
  wire        startReq;
  wire [7:0]  startOp;
  wire [3:0]  fieldsLeft;
  wire [31:0] statusWord;
  wire [31:0] addrMerged;

  // Merges a bus write into an old word under the byte strobes.
  function [31:0] fplMerge;
    input [31:0] oldV;
    input [31:0] newV;
    input [3:0]  strb;
    begin
      fplMerge = {strb[3] ? newV[31:24] : oldV[31:24],
                  strb[2] ? newV[23:16] : oldV[23:16],
                  strb[1] ? newV[15:8]  : oldV[15:8],
                  strb[0] ? newV[7:0]   : oldV[7:0]};
    end
  endfunction

  // --------------------------------------------------------------------
  // Datapath units
  // --------------------------------------------------------------------
  fpl_twos_comp uNeg (
    .operand     (tOperand),
    .negated     (negVal),
    .negZero     (negZero),
    .negOverflow (negOvf)
  );

  fpl_word_pick uPick (
    .dword     (dwordBuf),
    .pickRight (pickRight),
    .word      (pickedWord)
  );

  // Bus write decode.
  assign doWrite    = awHeld && wHeld && !s_axil_bvalid;
  assign wrGpr      = (awAddrQ[7:6] == `FPL_GPR_SEL);
  assign wrHit      = (awAddrQ == `FPL_OFF_CTRL) || (awAddrQ == `FPL_OFF_ADDR) ||
                      (awAddrQ == `FPL_OFF_STAT) || wrGpr;
  assign startReq   = doWrite && (awAddrQ == `FPL_OFF_CTRL) && !busy;
  assign startOp    = wDataQ[`FPL_CTRL_OP_HI:`FPL_CTRL_OP_LO];
  assign fieldsLeft = thirdRegField - firstRegField;
  assign addrMerged = fplMerge({8'h00, opAddr}, wDataQ, wStrbQ);
  assign statusWord = {26'h0000000, specIntr, ovfFlag, zeroFlag, condCode, busy};

  // --------------------------------------------------------------------
  // Local store write port and word selection
  // --------------------------------------------------------------------
  // Chooses what the sequencer writes into the local store this cycle.
  always @* begin
    seqWe     = 1'b0;
    seqWa     = firstRegField;
    seqWd     = tOperand;
    pickRight = opAddr[`FPL_WSEL_BIT];
    case (state)
      S_SIGN1: begin
        seqWe = 1'b1;
        seqWd = (opCode == `FPL_OP_LOAD_COMPL) ? negVal : tOperand;
      end
      S_SIGN2: begin
        seqWe = 1'b1;
        seqWd = negVal;
      end
      S_CMP1: begin
        seqWe = (firstRegField == thirdRegField);
        seqWd = pickedWord;
      end
      S_LEFT: begin
        seqWe     = 1'b1;
        pickRight = 1'b0;
        seqWd     = pickedWord;
      end
      S_RIGHT, S_ALIGN: begin
        seqWe     = 1'b1;
        pickRight = 1'b1;
        seqWd     = pickedWord;
      end
      default: begin
        seqWe = 1'b0;
      end
    endcase
  end

  // Local store flip-flops; the sequencer owns them while busy.
  always @(posedge sys_clk) begin
    if (seqWe) begin
      localStore[seqWa] <= seqWd;
    end else if (doWrite && wrGpr && !busy) begin
      localStore[awAddrQ[5:2]] <= fplMerge(localStore[awAddrQ[5:2]], wDataQ, wStrbQ);
    end
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  // Steps every operation and holds flags, code and operand address.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      state         <= S_IDLE;
      opCode        <= 8'h00;
      firstRegField <= 4'h0;
      thirdRegField <= 4'h0;
      thirdWork     <= 4'h0;
      opAddr        <= 24'h000000;
      workF         <= 8'h00;
      dwordBuf      <= 64'h0000000000000000;
      tOperand      <= 32'h00000000;
      zeroFlag      <= 1'b0;
      ovfFlag       <= 1'b0;
      condCode      <= `FPL_CC_ZERO;
      specIntr      <= 1'b0;
      busy          <= 1'b0;
      stReq         <= 1'b0;
      stAddr        <= 24'h000000;
    end else begin
      stReq <= 1'b0;
      // The interruption flag is cleared by writing one; a new check wins.
      if (doWrite && (awAddrQ == `FPL_OFF_STAT) && wStrbQ[0] && wDataQ[`FPL_STAT_SPEC]) begin
        specIntr <= 1'b0;
      end
      if (doWrite && (awAddrQ == `FPL_OFF_ADDR) && !busy) begin
        opAddr <= addrMerged[23:0];
      end
      case (state)
        S_IDLE: begin
          if (startReq) begin
            opCode        <= startOp;
            firstRegField <= wDataQ[`FPL_CTRL_F1_HI:`FPL_CTRL_F1_LO];
            thirdRegField <= wDataQ[`FPL_CTRL_F2_HI:`FPL_CTRL_F2_LO];
            tOperand      <= localStore[wDataQ[`FPL_CTRL_F2_HI:`FPL_CTRL_F2_LO]];
            workF         <= `FPL_F_PRESET;
            if (startOp == `FPL_OP_LOAD_MULTI) begin
              busy <= 1'b1;
              if (opAddr[1:0] != 2'h0) begin
                specIntr <= 1'b1;
                state    <= S_ENDOP;
              end else begin
                stReq  <= 1'b1;
                stAddr <= {opAddr[23:3], 3'h0};
                state  <= S_FETCH0;
              end
            end else if ((startOp == `FPL_OP_LOAD_COMPL) || (startOp == `FPL_OP_LOAD_ABS) ||
                         (startOp == `FPL_OP_LOAD_NEGMAG)) begin
              busy  <= 1'b1;
              state <= S_SIGN1;
            end
          end
        end
        S_SIGN1: begin
          zeroFlag <= negZero;
          ovfFlag  <= (opCode == `FPL_OP_LOAD_COMPL) ? negOvf : 1'b0;
          if ((opCode == `FPL_OP_LOAD_ABS) && tOperand[31]) begin
            state <= S_SIGN2;
          end else if ((opCode == `FPL_OP_LOAD_NEGMAG) && !tOperand[31]) begin
            state <= S_SIGN2;
          end else begin
            state <= S_ENDOP;
          end
        end
        S_SIGN2: begin
          ovfFlag <= (opCode == `FPL_OP_LOAD_ABS) ? negOvf : 1'b0;
          state   <= S_ENDOP;
        end
        S_FETCH0: begin
          if (stDataValid) begin
            dwordBuf <= storageDataOutBus;
            state    <= S_CMP1;
          end
        end
        S_CMP1: begin
          if (firstRegField == thirdRegField) begin
            state <= S_ENDOP;
          end else begin
            opAddr    <= opAddr + `FPL_DW_STEP;
            thirdWork <= thirdRegField - 4'h1;
            workF     <= {1'b0, workF[6:0]};
            state     <= S_BRANCH;
          end
        end
        S_BRANCH: begin
          if (!opAddr[`FPL_WSEL_BIT] && (firstRegField == thirdWork)) begin
            state <= S_LEFT;
          end else if (!opAddr[`FPL_WSEL_BIT]) begin
            stReq  <= 1'b1;
            stAddr <= {opAddr[23:3], 3'h0};
            opAddr <= opAddr + `FPL_DW_STEP;
            state  <= S_LEFT;
          end else if (firstRegField == thirdWork) begin
            stReq  <= 1'b1;
            stAddr <= {opAddr[23:3], 3'h0};
            state  <= S_RIGHT;
          end else begin
            stReq  <= 1'b1;
            stAddr <= {opAddr[23:3], 3'h0};
            workF  <= {workF[3:0], workF[7:4]};
            state  <= S_ALIGN;
          end
        end
        S_ALIGN: begin
          firstRegField <= firstRegField + 4'h1;
          opAddr        <= opAddr + {20'h00000, workF[3:0]};
          state         <= S_WAIT;
        end
        S_WAIT: begin
          if (stDataValid) begin
            dwordBuf <= storageDataOutBus;
            if (fieldsLeft >= 4'h2) begin
              stReq  <= 1'b1;
              stAddr <= {opAddr[23:3], 3'h0};
              opAddr <= opAddr + `FPL_DW_STEP;
            end
            state <= S_LEFT;
          end
        end
        S_LEFT: begin
          if (firstRegField == thirdRegField) begin
            state <= S_ENDOP;
          end else begin
            firstRegField <= firstRegField + 4'h1;
            state         <= S_RIGHT;
          end
        end
        S_RIGHT: begin
          if (firstRegField == thirdRegField) begin
            state <= S_ENDOP;
          end else begin
            firstRegField <= firstRegField + 4'h1;
            state         <= S_WAIT;
          end
        end
        S_ENDOP: begin
          busy  <= 1'b0;
          state <= S_IDLE;
          if (opCode == `FPL_OP_LOAD_COMPL) begin
            condCode <= ovfFlag ? `FPL_CC_OVF : zeroFlag ? `FPL_CC_ZERO :
                        negVal[31] ? `FPL_CC_NEG : `FPL_CC_POS;
          end else if (opCode == `FPL_OP_LOAD_ABS) begin
            condCode <= ovfFlag ? `FPL_CC_OVF : zeroFlag ? `FPL_CC_ZERO : `FPL_CC_POS;
          end else if (opCode == `FPL_OP_LOAD_NEGMAG) begin
            condCode <= zeroFlag ? `FPL_CC_ZERO : `FPL_CC_NEG;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read decode
  // --------------------------------------------------------------------
  // Picks the read word; unmapped addresses answer with an error.
  always @* begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    if (s_axil_araddr == `FPL_OFF_CTRL) begin
      rdMux = {16'h0000, opCode, firstRegField, thirdRegField};
    end else if (s_axil_araddr == `FPL_OFF_ADDR) begin
      rdMux = {8'h00, opAddr};
    end else if (s_axil_araddr == `FPL_OFF_STAT) begin
      rdMux = statusWord;
    end else if (s_axil_araddr[7:6] == `FPL_GPR_SEL) begin
      rdMux = localStore[s_axil_araddr[5:2]];
    end else begin
      rdHit = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite handshakes
  // --------------------------------------------------------------------
  // Takes address and data in either order, answers once both are held.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      s_axil_awready <= 1'b0;
      s_axil_wready  <= 1'b0;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= `FPL_RESP_OKAY;
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b0;
      s_axil_rresp   <= `FPL_RESP_OKAY;
      s_axil_rdata   <= 32'h00000000;
      awHeld         <= 1'b0;
      wHeld          <= 1'b0;
      awAddrQ        <= 8'h00;
      wDataQ         <= 32'h00000000;
      wStrbQ         <= 4'h0;
    end else begin
      if (s_axil_awready && s_axil_awvalid) begin
        s_axil_awready <= 1'b0;
        awHeld         <= 1'b1;
        awAddrQ        <= {s_axil_awaddr[7:2], 2'h0};
      end else if (!awHeld && !s_axil_bvalid) begin
        s_axil_awready <= 1'b1;
      end
      if (s_axil_wready && s_axil_wvalid) begin
        s_axil_wready <= 1'b0;
        wHeld         <= 1'b1;
        wDataQ        <= s_axil_wdata;
        wStrbQ        <= s_axil_wstrb;
      end else if (!wHeld && !s_axil_bvalid) begin
        s_axil_wready <= 1'b1;
      end
      if (doWrite) begin
        awHeld        <= 1'b0;
        wHeld         <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= wrHit ? `FPL_RESP_OKAY : `FPL_RESP_SLVERR;
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
      if (s_axil_arready && s_axil_arvalid) begin
        s_axil_arready <= 1'b0;
        s_axil_rvalid  <= 1'b1;
        s_axil_rdata   <= rdMux;
        s_axil_rresp   <= rdHit ? `FPL_RESP_OKAY : `FPL_RESP_SLVERR;
      end else if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end else if (!s_axil_rvalid) begin
        s_axil_arready <= 1'b1;
      end
    end
  end

endmodule // fpl_exec

// *** dv/fpl_exec_props.sv ***
/* Checker on fpl_exec ports: storage requests, bus handshakes.
   Assumes a bind to fpl_exec. */
`timescale 1ns/1ps
module fpl_exec_props (
  input wire        sys_clk,
  input wire        nrst,
  input wire        s_axil_awready,
  input wire        s_axil_wready,
  input wire [1:0]  s_axil_bresp,
  input wire        s_axil_bvalid,
  input wire        s_axil_bready,
  input wire        s_axil_arready,
  input wire [31:0] s_axil_rdata,
  input wire        s_axil_rvalid,
  input wire        s_axil_rready,
  input wire        stReq,
  input wire        [23:0] stAddr
);
  // ------------------------------------------------------------------
  // Port relations.
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_req_align; stReq |-> stAddr[2:0] == 3'h0; endproperty
  a_req_align: assert property (p_req_align) else $error("misaligned request");
  property p_req_pulse; stReq |=> !stReq; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("long request");
  property p_addr_hold; !stReq |-> $stable(stAddr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_b_hold; s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_b_end; s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid; endproperty
  a_b_end: assert property (p_b_end) else $error("bvalid repeated");
  property p_r_hold; s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_w_block; s_axil_bvalid |-> !s_axil_awready && !s_axil_wready; endproperty
  a_w_block: assert property (p_w_block) else $error("write ready while bvalid");
  property p_r_block; s_axil_rvalid |-> !s_axil_arready; endproperty
  a_r_block: assert property (p_r_block) else $error("read ready while rvalid");
endmodule // fpl_exec_props

// *** dv/fpl_store_model.sv ***
/* Storage unit model: answers each doubleword request in order.
   Assumes one-cycle requests; lat sets the delay. */
`timescale 1ns/1ps
module fpl_store_model (
  input  wire        sys_clk,
  input  wire        stReq,
  input  wire [23:0] stAddr,
  input  wire [3:0]  lat,
  output reg         stDataValid,
  output reg  [63:0] storageDataOutBus
);
  logic [23:0] pend[$];
  int          age = 0;
  initial begin
    stDataValid = 1'b0;
    storageDataOutBus = 64'h0;
  end
  // Words carry their address; the idle bus toggles.
  always @(posedge sys_clk) begin
    stDataValid <= 1'b0;
    storageDataOutBus <= ~storageDataOutBus;
    if (stReq === 1'b1) pend.push_back(stAddr);
    if (pend.size() > 0 && age >= lat) begin
      stDataValid <= 1'b1;
      storageDataOutBus <= {8'hc3, pend[0], 8'hc3, pend[0] + 24'h4};
      void'(pend.pop_front());
      age = 0;
    end else if (pend.size() > 0) age++;
  end
endmodule // fpl_store_model

// *** dv/fpl_exec_tb_top.sv ***
/* Self-checking bench for fpl_exec over AXI4-Lite with a storage model.
   Assumes the design, store model and checker are compiled. */
`timescale 1ns/1ps
`include "fpl_consts.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module fpl_exec_tb_top;
  logic sys_clk, nrst, awValid, wValid, bReady, arValid, rReady, awReady, wReady, bValid, arReady, rValid;
  logic stReq, stDv;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [1:0] bResp, rResp;
  logic [23:0] stAddr;
  logic [63:0] stBus;
  logic [3:0] lat;
  int miscompares, cmp_count, reqCount;
  logic [7:0] ops[3] = '{`FPL_OP_LOAD_COMPL, `FPL_OP_LOAD_ABS, `FPL_OP_LOAD_NEGMAG};
  logic [31:0] vals[5] = '{32'h0, 32'h5, 32'hfffffffb, 32'h80000000, 32'h7fffffff};
  fpl_exec dut_u (.sys_clk(sys_clk), .nrst(nrst), .s_axil_awaddr(awAddr), .s_axil_awvalid(awValid),
    .s_axil_awready(awReady), .s_axil_wdata(wData), .s_axil_wstrb(4'hf), .s_axil_wvalid(wValid),
    .s_axil_wready(wReady), .s_axil_bresp(bResp), .s_axil_bvalid(bValid), .s_axil_bready(bReady),
    .s_axil_araddr(arAddr), .s_axil_arvalid(arValid), .s_axil_arready(arReady), .s_axil_rdata(rData),
    .s_axil_rresp(rResp), .s_axil_rvalid(rValid), .s_axil_rready(rReady), .stReq(stReq),
    .stAddr(stAddr), .stDataValid(stDv), .storageDataOutBus(stBus));
  fpl_store_model store_u (.sys_clk(sys_clk), .stReq(stReq), .stAddr(stAddr), .lat(lat),
    .stDataValid(stDv), .storageDataOutBus(stBus));
  // ------------------------------------------------------------------
  // Clock, request count, report.
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (stReq === 1'b1) reqCount++;
  task automatic wrap_up();
    $display("cmp %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo(inout int n);
    n++;
    if (n > 400) begin
      miscompares++;
      wrap_up();
    end
  endtask
  // ------------------------------------------------------------------
  // Bus tasks.
  // ------------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    bit ad = 0, dd = 0;
    @(posedge sys_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge sys_clk);
      tmo(n);
      if (!ad && awReady === 1'b1) begin
        ad = 1;
        awValid <= 1'b0;
      end
      if (!dd && wReady === 1'b1) begin
        dd = 1;
        wValid <= 1'b0;
      end
    end
    while (bValid !== 1'b1) begin
      @(posedge sys_clk);
      tmo(n);
    end
    bReady <= 1'b1;
    @(posedge sys_clk);
    r = bResp;
    bReady <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    arAddr <= a;
    arValid <= 1'b1;
    do begin
      @(posedge sys_clk);
      tmo(n);
    end while (arReady !== 1'b1);
    arValid <= 1'b0;
    while (rValid !== 1'b1) begin
      @(posedge sys_clk);
      tmo(n);
    end
    rReady <= 1'b1;
    @(posedge sys_clk);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
  endtask
  task automatic idle();
    logic [31:0] s;
    logic [1:0] r;
    int n = 0;
    do begin
      axr(`FPL_OFF_STAT, s, r);
      tmo(n);
    end while (s[0] !== 1'b0);
  endtask
  // ------------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------------
  task automatic t_sign(input logic [7:0] op, input logic [31:0] v);
    logic [31:0] x, s;
    logic [1:0] r, cc;
    logic ov;
    // Which ops negate the operand.
    x = (op == `FPL_OP_LOAD_COMPL || (op == `FPL_OP_LOAD_ABS) == v[31]) ? -v : v;
    ov = op != `FPL_OP_LOAD_NEGMAG && v == 32'h80000000;
    cc = ov ? 2'h3 : (x == 32'h0) ? 2'h0 : x[31] ? 2'h1 : 2'h2;
    axw(8'h48, v, r);
    axw(`FPL_OFF_CTRL, {16'h0, op, 8'h12}, r);
    idle();
    axr(8'h44, s, r);
    `CHK("result", x, s)
    axr(`FPL_OFF_STAT, s, r);
    `CHK("flags and code", {ov, x == 32'h0, cc}, s[4:1])
  endtask
  task automatic t_multi(input logic [3:0] f, input logic [3:0] t, input logic [23:0] a);
    logic [31:0] s;
    logic [1:0] r, cc;
    int q, nw;
    for (int i = 0; i < 16; i++) axw(8'(8'h40 + 4 * i), 32'h5a5a5a5a, r);
    axw(`FPL_OFF_ADDR, {8'h0, a}, r);
    axr(`FPL_OFF_STAT, s, r);
    cc = s[2:1];
    q = reqCount;
    nw = 4'(t - f) + 1;
    axw(`FPL_OFF_CTRL, {16'h0, `FPL_OP_LOAD_MULTI, f, t}, r);
    idle();
    for (int i = 0; i < 16; i++) begin
      axr(8'(8'h40 + 4 * i), s, r);
      `CHK("gpr", (4'(i - f) < nw) ? {8'hc3, 24'(a + 4 * 4'(i - f))} : 32'h5a5a5a5a, s)
    end
    `CHK("requests", (a[2] + nw + 1) / 2, reqCount - q)
    axr(`FPL_OFF_STAT, s, r);
    `CHK("code kept", cc, s[2:1])
  endtask
  task automatic t_spec();
    logic [31:0] g, s;
    logic [1:0] r;
    int q;
    axr(8'h40, g, r);
    axw(`FPL_OFF_ADDR, 32'h102, r);
    q = reqCount;
    axw(`FPL_OFF_CTRL, {16'h0, `FPL_OP_LOAD_MULTI, 8'h01}, r);
    idle();
    axr(8'h40, s, r);
    `CHK("gpr kept", g, s)
    `CHK("no request", 0, reqCount - q)
    axr(`FPL_OFF_STAT, s, r);
    `CHK("spec set", 1'b1, s[5])
    axw(`FPL_OFF_STAT, 32'h20, r);
    axr(`FPL_OFF_STAT, s, r);
    `CHK("spec clear", 1'b0, s[5])
  endtask
  task automatic t_bad();
    logic [31:0] s;
    logic [1:0] r;
    axr(8'h3c, s, r);
    `CHK("bad read", {`FPL_RESP_SLVERR, 32'h0}, {r, s})
    axw(8'h0c, 32'h1, r);
    `CHK("bad write", `FPL_RESP_SLVERR, r)
  endtask
  // Reset, sign loads on boundary operands, each load-multiple branch.
  initial begin
    {nrst, awValid, wValid, bReady, arValid, rReady, awAddr, arAddr, wData} = '0;
    lat = 4'h0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (ops[i]) foreach (vals[j]) t_sign(ops[i], vals[j]);
    t_multi(4'h5, 4'h5, 24'h100);
    t_multi(4'h5, 4'h5, 24'h104);
    lat <= 4'h3;
    t_multi(4'h0, 4'h1, 24'h100);
    t_multi(4'h0, 4'h1, 24'h104);
    t_multi(4'he, 4'h1, 24'h204);
    t_multi(4'h3, 4'h2, 24'h300);
    t_spec();
    t_bad();
    wrap_up();
  end
endmodule // fpl_exec_tb_top
bind fpl_exec fpl_exec_props chk_u (.sys_clk(sys_clk), .nrst(nrst), .s_axil_awready(s_axil_awready),
  .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
  .s_axil_bready(s_axil_bready), .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
  .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready), .stReq(stReq), .stAddr(stAddr));
